/* File: hdl/amc_master_clock_config.sv */
`timescale 1ns/1ps
`default_nettype none
module amc_master_clock_config
  import amc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic busClockIn,
  input wire logic frameSyncIn,
  input wire logic busClockGen,
  input wire logic frameSyncGen,
  output logic busClockOut,
  output logic busClockOe,
  output logic frameSyncOut,
  output logic frameSyncOe,
  output logic masterMode,
  output logic autoConfig,
  output logic loopEnable,
  output logic rateFamily44k,
  output logic useFreqCode,
  output logic [2:0] referenceFreqCode,
  output logic useProgrammed,
  output logic [3:0] programmedRate,
  output logic [3:0] programmedRatio
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] setupA_reg;
  logic [7:0] setupB_reg;
  logic [7:0] clockSource_reg;
  logic [7:0] monitor_reg;
  logic [7:0] monitor_next;

  wire selA = (regAddr == SETUP_A_OFFSET);
  wire selB = (regAddr == SETUP_B_OFFSET);
  wire selMon = (regAddr == MONITOR_OFFSET);
  wire selSrc = (regAddr == CLOCK_SOURCE_OFFSET);

  // Monitor is read only; writes to it are dropped
  wire wrA = regWrite & selA;
  wire wrB = regWrite & selB;
  wire wrSrc = regWrite & selSrc;

  always_ff @(posedge clock) begin
    if (rst) setupA_reg <= SETUP_A_RESET;
    else if (wrA) setupA_reg <= regWrData;
  end

  always_ff @(posedge clock) begin
    if (rst) setupB_reg <= SETUP_B_RESET;
    else if (wrB) setupB_reg <= regWrData;
  end

  always_ff @(posedge clock) begin
    if (rst) clockSource_reg <= CLOCK_SOURCE_RESET;
    else if (wrSrc) clockSource_reg <= regWrData;
  end

  wire [7:0] readMux = selA ? setupA_reg :
                       selB ? setupB_reg :
                       selMon ? monitor_reg :
                       selSrc ? clockSource_reg : 8'h00;

  always_ff @(posedge clock) begin
    if (rst) regRdData <= 8'h00;
    else if (regRead) regRdData <= readMux;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded configuration
  wire isMaster = setupA_reg[ROLE_BIT];
  wire isAuto = ~setupA_reg[AUTO_OFF_BIT];
  wire loopOn = isAuto ? ~setupA_reg[LOOP_DIS_BIT] : 1'b1;
  wire gateOn = isMaster & setupA_reg[GATE_BIT];
  wire family = isMaster & setupA_reg[FAMILY_BIT];
  wire methodCode = ~clockSource_reg[FREQ_METHOD_BIT];
  wire freqCodeUsed = isMaster & methodCode;
  wire progUsed = ~(~isMaster & isAuto);

  always_ff @(posedge clock) begin
    if (rst) begin
      masterMode <= 1'b0;
      autoConfig <= 1'b1;
      loopEnable <= 1'b1;
      rateFamily44k <= 1'b0;
      useFreqCode <= 1'b0;
      referenceFreqCode <= SETUP_A_RESET[2:0];
      useProgrammed <= 1'b0;
      programmedRate <= SETUP_B_RESET[7:4];
      programmedRatio <= SETUP_B_RESET[3:0];
    end else begin
      masterMode <= isMaster;
      autoConfig <= isAuto;
      loopEnable <= loopOn;
      rateFamily44k <= family;
      useFreqCode <= freqCodeUsed;
      referenceFreqCode <= setupA_reg[FREQ_CODE_LSB +: 3];
      useProgrammed <= progUsed;
      programmedRate <= setupB_reg[RATE_LSB +: 4];
      programmedRatio <= setupB_reg[RATIO_LSB +: 4];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive: master drives both, gated forces them low
  always_ff @(posedge clock) begin
    if (rst) begin
      busClockOut <= 1'b0;
      frameSyncOut <= 1'b0;
      busClockOe <= 1'b0;
      frameSyncOe <= 1'b0;
    end else begin
      busClockOe <= isMaster;
      frameSyncOe <= isMaster;
      busClockOut <= busClockGen & ~gateOn;
      frameSyncOut <= frameSyncGen & ~gateOn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: change counts when stages two and three agree
  logic [2:0] bclkSync_reg;
  logic [2:0] fsSync_reg;
  logic bclkLevel_reg;
  logic fsLevel_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      bclkSync_reg <= 3'h0;
      fsSync_reg <= 3'h0;
      bclkLevel_reg <= 1'b0;
      fsLevel_reg <= 1'b0;
    end else begin
      bclkSync_reg <= {bclkSync_reg[1:0], busClockIn};
      fsSync_reg <= {fsSync_reg[1:0], frameSyncIn};
      if (bclkSync_reg[1] == bclkSync_reg[2]) bclkLevel_reg <= bclkSync_reg[2];
      if (fsSync_reg[1] == fsSync_reg[2]) fsLevel_reg <= fsSync_reg[2];
    end
  end

  // Measure our own generators when master, even while gated, and the synchronised pins when slave
  wire bclkSample = isMaster ? busClockGen : bclkLevel_reg;
  wire fsSample = isMaster ? frameSyncGen : fsLevel_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Rate and ratio measurement
  logic bclkPrev_reg;
  logic fsPrev_reg;
  logic [RATIO_CNT_W-1:0] bclkCount_reg;
  logic [RATE_CNT_W-1:0] coreCount_reg;
  logic [3:0] ratioCand_reg;
  logic [3:0] rateCand_reg;
  logic [2:0] agree_reg;

  wire bclkRise = bclkSample & ~bclkPrev_reg;
  wire fsRise = fsSample & ~fsPrev_reg;

  function automatic logic [3:0] ratio_code(input logic [RATIO_CNT_W-1:0] n);
    case (n)
      12'd16: ratio_code = 4'h0;
      12'd24: ratio_code = 4'h1;
      12'd32: ratio_code = 4'h2;
      12'd48: ratio_code = 4'h3;
      12'd64: ratio_code = 4'h4;
      12'd96: ratio_code = 4'h5;
      12'd128: ratio_code = 4'h6;
      12'd192: ratio_code = 4'h7;
      12'd256: ratio_code = 4'h8;
      12'd384: ratio_code = 4'h9;
      12'd512: ratio_code = 4'ha;
      12'd1024: ratio_code = 4'hb;
      12'd2048: ratio_code = 4'hc;
      default: ratio_code = INVALID_CODE;
    endcase
  endfunction : ratio_code

  // Wide windows so one code covers both rate families
  function automatic logic in_window(input logic [RATE_CNT_W-1:0] n,
    input logic [RATE_CNT_W-1:0] lo, input logic [RATE_CNT_W-1:0] hi);
    in_window = (n >= lo) && (n <= hi);
  endfunction : in_window

  // Core clocks per frame; each window spans both families' rates, from about -4 % to +2 % beyond them
  function automatic logic [3:0] rate_code(input logic [RATE_CNT_W-1:0] n);
    if (in_window(n, RATE0_LO, RATE0_HI)) rate_code = 4'h0;
    else if (in_window(n, RATE1_LO, RATE1_HI)) rate_code = 4'h1;
    else if (in_window(n, RATE2_LO, RATE2_HI)) rate_code = 4'h2;
    else if (in_window(n, RATE3_LO, RATE3_HI)) rate_code = 4'h3;
    else if (in_window(n, RATE4_LO, RATE4_HI)) rate_code = 4'h4;
    else if (in_window(n, RATE5_LO, RATE5_HI)) rate_code = 4'h5;
    else if (in_window(n, RATE6_LO, RATE6_HI)) rate_code = 4'h6;
    else if (in_window(n, RATE7_LO, RATE7_HI)) rate_code = 4'h7;
    else if (in_window(n, RATE8_LO, RATE8_HI)) rate_code = 4'h8;
    else rate_code = INVALID_CODE;
  endfunction : rate_code

  wire [3:0] ratioNow = ratio_code(bclkCount_reg);
  wire [3:0] rateNow = rate_code(coreCount_reg);
  wire sameAsLast = (ratioNow == ratioCand_reg) && (rateNow == rateCand_reg);
  wire coreSat = &coreCount_reg;
  wire bclkFull = &bclkCount_reg;
  wire stable = (agree_reg == STABLE_FRAMES);

  // Edge history; idle pins are low, so reset low avoids a false edge
  always_ff @(posedge clock) begin
    if (rst) begin
      bclkPrev_reg <= 1'b0;
      fsPrev_reg <= 1'b0;
    end else begin
      bclkPrev_reg <= bclkSample;
      fsPrev_reg <= fsSample;
    end
  end

  // Bus clock rises in the current frame
  always_ff @(posedge clock) begin
    if (rst) begin
      bclkCount_reg <= '0;
    end else if (fsRise) begin
      bclkCount_reg <= '0;
    end else if (bclkRise && !bclkFull) begin
      bclkCount_reg <= bclkCount_reg + 12'h1;
    end
  end

  // Core clocks in the current frame; saturates when frame sync is lost
  always_ff @(posedge clock) begin
    if (rst) begin
      coreCount_reg <= '0;
    end else if (fsRise) begin
      coreCount_reg <= '0;
    end else if (!coreSat) begin
      coreCount_reg <= coreCount_reg + 16'h1;
    end
  end

  // Codes of the frame just closed
  always_ff @(posedge clock) begin
    if (rst) begin
      ratioCand_reg <= INVALID_CODE;
      rateCand_reg <= INVALID_CODE;
    end else if (fsRise) begin
      ratioCand_reg <= ratioNow;
      rateCand_reg <= rateNow;
    end
  end

  // Lock needs several agreeing frames; a lost frame sync drops it
  always_ff @(posedge clock) begin
    if (rst) begin
      agree_reg <= 3'h0;
    end else if (fsRise) begin
      if (!sameAsLast) agree_reg <= 3'h0;
      else if (!stable) agree_reg <= agree_reg + 3'h1;
    end else if (coreSat) begin
      agree_reg <= 3'h0;
    end
  end

  // Invalid until a stable measurement; reads never disturb it
  always_comb begin
    monitor_next = MONITOR_RESET;
    if (stable && ratioCand_reg != INVALID_CODE
        && rateCand_reg != INVALID_CODE) begin
      monitor_next[RATE_LSB +: 4] = rateCand_reg;
      monitor_next[RATIO_LSB +: 4] = ratioCand_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) monitor_reg <= MONITOR_RESET;
    else monitor_reg <= monitor_next;
  end

endmodule : amc_master_clock_config
`default_nettype wire

/* File: hdl/amc_pkg.sv */
package amc_pkg;
  // Register offsets
  localparam logic [7:0] SETUP_A_OFFSET = 8'h13;
  localparam logic [7:0] SETUP_B_OFFSET = 8'h14;
  localparam logic [7:0] MONITOR_OFFSET = 8'h15;
  localparam logic [7:0] CLOCK_SOURCE_OFFSET = 8'h16;
  // Reset values
  localparam logic [7:0] SETUP_A_RESET = 8'h02;
  localparam logic [7:0] SETUP_B_RESET = 8'h48;
  localparam logic [7:0] MONITOR_RESET = 8'hff;
  localparam logic [7:0] CLOCK_SOURCE_RESET = 8'h10;
  // Field positions, setup A
  localparam int ROLE_BIT = 7;
  localparam int AUTO_OFF_BIT = 6;
  localparam int LOOP_DIS_BIT = 5;
  localparam int GATE_BIT = 4;
  localparam int FAMILY_BIT = 3;
  localparam int FREQ_CODE_LSB = 0;
  // Field positions, setup B and monitor
  localparam int RATE_LSB = 4;
  localparam int RATIO_LSB = 0;
  // Clock source register field
  localparam int FREQ_METHOD_BIT = 6;
  // Code limits
  localparam logic [3:0] RATE_MAX_CODE = 4'h8;
  localparam logic [3:0] RATIO_MAX_CODE = 4'hc;
  localparam logic [3:0] INVALID_CODE = 4'hf;
  // Frames of agreement before a measurement counts as stable
  localparam logic [2:0] STABLE_FRAMES = 3'h3;
  // Ratio measurement counter width (up to 2048 bus clocks)
  localparam int RATIO_CNT_W = 12;
  // Core clock ticks per frame counter width
  localparam int RATE_CNT_W = 16;
  // Core clocks per frame accepted for each rate code, both families
  localparam logic [15:0] RATE0_LO = 16'd30000;
  localparam logic [15:0] RATE0_HI = 16'd34800;
  localparam logic [15:0] RATE1_LO = 16'd15000;
  localparam logic [15:0] RATE1_HI = 16'd17400;
  localparam logic [15:0] RATE2_LO = 16'd10000;
  localparam logic [15:0] RATE2_HI = 16'd11600;
  localparam logic [15:0] RATE3_LO = 16'd7500;
  localparam logic [15:0] RATE3_HI = 16'd8700;
  localparam logic [15:0] RATE4_LO = 16'd5000;
  localparam logic [15:0] RATE4_HI = 16'd5800;
  localparam logic [15:0] RATE5_LO = 16'd2500;
  localparam logic [15:0] RATE5_HI = 16'd2900;
  localparam logic [15:0] RATE6_LO = 16'd1250;
  localparam logic [15:0] RATE6_HI = 16'd1450;
  localparam logic [15:0] RATE7_LO = 16'd625;
  localparam logic [15:0] RATE7_HI = 16'd725;
  localparam logic [15:0] RATE8_LO = 16'd312;
  localparam logic [15:0] RATE8_HI = 16'd363;
  // Core clock frequency in MHz (core clocks per microsecond)
  localparam int CLOCK_MHZ = 250;
endpackage : amc_pkg

/* File: verification/amc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module amc_monitor
  import amc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic busClockGen,
  input wire logic busClockOut,
  input wire logic busClockOe,
  input wire logic frameSyncOut,
  input wire logic frameSyncOe,
  input wire logic masterMode,
  input wire logic autoConfig,
  input wire logic loopEnable,
  input wire logic rateFamily44k,
  input wire logic [2:0] referenceFreqCode,
  input wire logic useProgrammed,
  input wire logic [3:0] programmedRate,
  input wire logic [3:0] programmedRatio
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [7:0] setupA_reg;
  logic [7:0] setupB_reg;
  wire logic wrA = regWrite && regAddr == SETUP_A_OFFSET;
  wire logic wrB = regWrite && regAddr == SETUP_B_OFFSET;
  // Shadow copies; decoded outputs lag them by one edge
  always_ff @(posedge clock) begin
    if (rst) begin
      setupA_reg <= SETUP_A_RESET;
      setupB_reg <= SETUP_B_RESET;
    end else begin
      if (wrA) setupA_reg <= regWrData;
      if (wrB) setupB_reg <= regWrData;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  AST_ROLE: assert property (!$past(wrA) |->
    masterMode == setupA_reg[7] && busClockOe == setupA_reg[7])
    else $error("role");
  AST_FSOE: assert property (!$past(wrA) |->
    frameSyncOe == setupA_reg[7]) else $error("frame oe");
  AST_AUTO: assert property (!$past(wrA) |->
    autoConfig == !setupA_reg[6]) else $error("auto");
  AST_LOOP: assert property (!$past(wrA) |->
    loopEnable == (setupA_reg[6] || !setupA_reg[5])) else $error("loop");
  AST_GATE: assert property (!$past(wrA) && masterMode && setupA_reg[4]
    |-> !busClockOut) else $error("gate");
  AST_FSGATE: assert property (!$past(wrA) && masterMode && setupA_reg[4]
    |-> !frameSyncOut) else $error("frame gate");
  AST_PASS: assert property (!$past(wrA) && masterMode && !setupA_reg[4]
    |-> busClockOut == $past(busClockGen)) else $error("pass");
  AST_FAMILY: assert property (!$past(wrA) && masterMode |->
    rateFamily44k == setupA_reg[3]) else $error("family");
  AST_REF: assert property (!$past(wrA) |->
    referenceFreqCode == setupA_reg[2:0]) else $error("refcode");
  AST_PROG: assert property (!$past(wrB) |->
    {programmedRate, programmedRatio} == setupB_reg) else $error("prog");
  AST_IGNORE: assert property (
    useProgrammed == (masterMode || !autoConfig)) else $error("ignore");
  AST_STATUS: assert property (regRead && regAddr == MONITOR_OFFSET |=>
    (regRdData[7:4] <= RATE_MAX_CODE || regRdData[7:4] == INVALID_CODE) &&
    (regRdData[3:0] <= RATIO_MAX_CODE || regRdData[3:0] == INVALID_CODE))
    else $error("status");
endmodule : amc_monitor
bind amc_master_clock_config amc_monitor amc_monitor_i (.*);
`default_nettype wire

/* File: verification/amc_bus_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module amc_bus_peer (
  input wire logic run,
  input wire logic [11:0] ratio,
  input wire logic [31:0] halfPs,
  output logic busClockIn,
  output logic frameSyncIn
);
  // Bus clock runs on between frames without a gap; both pins rest low only while run is low
  always begin
    busClockIn = 1'b0;
    frameSyncIn = 1'b0;
    wait (run);
    for (int i = 0; i < int'(ratio); i++) begin
      frameSyncIn = (i == 0);
      #(halfPs * 1ps) busClockIn = 1'b1;
      #(halfPs * 1ps) busClockIn = 1'b0;
    end
  end
endmodule : amc_bus_peer
`default_nettype wire

/* File: verification/amc_master_clock_config_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin \
  check_count++; \
  if ((a) !== (e)) begin \
    mismatches++; \
    $display("BAD %0t %h %h", $time, (a), (e)); \
  end \
end
module amc_master_clock_config_test;
  import amc_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic busClockGen = 1'b0;
  logic frameSyncGen = 1'b0;
  logic run = 1'b0;
  logic [11:0] ratio = 12'h010;
  logic [31:0] halfPs = 32'h00009ef2;
  logic [31:0] seed = 32'h00013a8d;
  int mismatches = 0;
  int check_count = 0;
  logic busClockIn, frameSyncIn, busClockOut, busClockOe, frameSyncOut;
  logic frameSyncOe, masterMode, autoConfig, loopEnable, rateFamily44k;
  logic useFreqCode, useProgrammed;
  logic [7:0] regRdData;
  logic [2:0] referenceFreqCode;
  logic [3:0] programmedRate, programmedRatio;
  amc_master_clock_config amc_master_clock_config_i (.*);
  amc_bus_peer amc_bus_peer_i (.*);
  always #2 clock = ~clock;
  always @(negedge clock) busClockGen <= ~busClockGen;
  always @(negedge clock) if (busClockGen) frameSyncGen <= ~frameSyncGen;
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function automatic logic [7:0] decoded(input logic [7:0] a, input logic m);
    return {a[7], ~a[6], a[6] | ~a[5], a[7] | a[6], a[7] & ~m, a[2:0]};
  endfunction : decoded
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    regWrite = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge clock);
    regWrite = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    regRead = 1'b1;
    regAddr = a;
    @(negedge clock);
    regRead = 1'b0;
    @(posedge clock);
    #1 d = regRdData;
  endtask : rd
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  // Polls the monitor; lock needs several agreeing frames
  task automatic lockTo(input logic [7:0] e);
    logic [7:0] d;
    int n;
    n = 0;
    d = 8'hff;
    while (d !== e && n < 20000) begin
      rd(MONITOR_OFFSET, d);
      n++;
    end
    `CHK(d, e)
    if (d !== e) summarize();
  endtask : lockTo
  //////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d, a, b, s;
    logic [31:0] r;
    logic [7:0] rv[4] = '{8'h02, 8'h48, 8'hff, 8'h10};
    logic [11:0] rt[3] = '{12'h010, 12'h020, 12'h040};
    logic [31:0] hp[3] = '{32'h00009ef2, 32'h00009ef2, 32'h00027bc8};
    logic [7:0] ex[3] = '{8'h80, 8'h72, 8'h44};
    repeat (10) @(negedge clock);
    rst = 1'b0;
    wr(MONITOR_OFFSET, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rd(SETUP_A_OFFSET + 8'(i), d);
      `CHK(d, rv[i])
    end
    rd(8'h20, d);
    `CHK(d, 8'h00)
    $display("test reset done");
    run = 1'b1;
    rd(MONITOR_OFFSET, d);
    `CHK(d, 8'hff)
    for (int i = 0; i < 3; i++) begin
      ratio = rt[i];
      halfPs = hp[i];
      lockTo(ex[i]);
    end
    $display("test monitor done");
    for (int i = 0; i < 12; i++) begin
      r = xs();
      a = (i == 0) ? 8'h98 : r[7:0];
      b = (i == 0) ? 8'h8c : {r[11:8] % 4'h9, r[15:12] % 4'hd};
      s = r[23:16];
      wr(SETUP_A_OFFSET, a);
      wr(SETUP_B_OFFSET, b);
      wr(CLOCK_SOURCE_OFFSET, s);
      rd(SETUP_A_OFFSET, d);
      `CHK(d, a)
      rd(SETUP_B_OFFSET, d);
      `CHK(d, b)
      rd(CLOCK_SOURCE_OFFSET, d);
      `CHK(d, s)
      `CHK({busClockOe, frameSyncOe}, {2{a[7]}})
      `CHK(busClockOut, busClockGen & ~(a[7] & a[4]))
      `CHK(frameSyncOut, frameSyncGen & ~(a[7] & a[4]))
      d = {masterMode, autoConfig, loopEnable, useProgrammed, useFreqCode,
        referenceFreqCode};
      `CHK(d, decoded(a, s[6]))
      `CHK({programmedRate, programmedRatio}, b)
      if (a[7]) `CHK(rateFamily44k, a[3])
    end
    $display("test registers done");
    summarize();
  end
endmodule : amc_master_clock_config_test
`default_nettype wire
